// >>> common/rcog_pkg.sv
// shared constants and types of the reference clock output generator
package rcog_pkg;

  // register byte addresses on the apb bus
  localparam logic [11:0] ADDR_CTL_LO = 12'h000;
  localparam logic [11:0] ADDR_CTL_HI = 12'h004;
  localparam logic [11:0] ADDR_TRIM = 12'h008;

  // field positions in the control low register
  localparam int BIT_EN = 15;
  localparam int BIT_SIDL = 13;
  localparam int BIT_OE = 12;
  localparam int BIT_SLP = 11;
  localparam int BIT_SWREQ = 9;
  localparam int BIT_ACT = 8;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 3;

  // field positions in the control high and trim registers
  localparam int DIV_LSB = 0;
  localparam int DIV_MSB = 14;
  localparam int TRIM_LSB = 7;
  localparam int TRIM_MSB = 15;

  // values after reset
  localparam logic [14:0] DIV_RST = 15'h0000;
  localparam logic [8:0] TRIM_RST = 9'h000;
  localparam logic [3:0] SEL_RST = 4'h0;

  // source select codes
  localparam logic [3:0] SRC_CPU = 4'h0;
  localparam logic [3:0] SRC_PERIPH = 4'h1;
  localparam logic [3:0] SRC_PRIMARY = 4'h2;
  localparam logic [3:0] SRC_FAST_RC = 4'h3;
  localparam logic [3:0] SRC_LOW_POWER_RC = 4'h4;
  localparam logic [3:0] SRC_SECONDARY = 4'h5;
  localparam logic [3:0] SRC_PLL = 4'h6;
  localparam logic [3:0] SRC_PIN = 4'h8;
  localparam int NUM_SRC = 9;

  // control fields that travel together
  typedef struct packed {
    logic en;
    logic sidl;
    logic oe;
    logic slp;
    logic [3:0] sel;
  } rcog_ctl_t;

  // apb slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RESP = 2'b01
  } rcog_bus_t;

endpackage : rcog_pkg

// >>> hdl/rcog_divider.sv
// glitch-free integer plus fractional divider for the reference clock
`timescale 1ns/1ps
module rcog_divider (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic tick_i,
  input wire logic src_lvl_i,
  input wire logic run_i,
  input wire logic load_i,
  input wire logic [14:0] div_i,
  input wire logic [8:0] trim_i,
  output logic clk_o,
  output logic active_o,
  output logic loaded_o
);

  logic out_r;
  logic act_r;
  logic ld_r;
  logic [15:0] cnt_r;
  logic [15:0] need_r;
  logic [8:0] acc_r;
  logic [14:0] div_r;
  logic [8:0] trim_r;
  logic pass;
  logic hit;
  logic bound;
  logic [9:0] run_sum;
  logic [9:0] init_sum;
  logic [14:0] init_div;

  // fraction accumulator step, carry out is one extra source edge
  function automatic logic [9:0] rcog_frac_sum(
    input logic [8:0] acc,
    input logic [8:0] trim
  );
    rcog_frac_sum = {1'b0, acc} + {1'b0, trim};
  endfunction : rcog_frac_sum

  // a zero divisor passes the base clock through
  assign pass = (div_r == 15'h0000);
  assign hit = tick_i && ((cnt_r + 16'h0001) == need_r);
  // period boundary is the falling edge of the output
  assign bound = act_r && (pass ? (out_r && !src_lvl_i)
                                : (hit && out_r));
  assign run_sum = rcog_frac_sum(acc_r, trim_r);
  assign init_div = load_i ? div_i : div_r;
  assign init_sum = rcog_frac_sum(9'h000, load_i ? trim_i : trim_r);

  // each half period lasts div plus trim/512 source edges
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      out_r <= 1'b0;
      act_r <= 1'b0;
      ld_r <= 1'b0;
      cnt_r <= 16'h0000;
      need_r <= 16'h0000;
      acc_r <= 9'h000;
      div_r <= rcog_pkg::DIV_RST;
      trim_r <= rcog_pkg::TRIM_RST;
    end
    else
    begin
      ld_r <= 1'b0;
      if (!act_r || bound)
      begin
        // new values only while stopped or at a boundary
        if (load_i)
        begin
          div_r <= div_i;
          trim_r <= trim_i;
          ld_r <= 1'b1;
        end
        if (!act_r || load_i)
        begin
          acc_r <= init_sum[8:0];
          need_r <= {1'b0, init_div} + {15'h0000, init_sum[9]};
        end
        else
        begin
          acc_r <= run_sum[8:0];
          need_r <= {1'b0, div_r} + {15'h0000, run_sum[9]};
        end
        cnt_r <= 16'h0000;
        out_r <= 1'b0;
        act_r <= run_i;
      end
      else if (pass)
        out_r <= src_lvl_i;
      else if (hit)
      begin
        out_r <= 1'b1;
        cnt_r <= 16'h0000;
        acc_r <= run_sum[8:0];
        need_r <= {1'b0, div_r} + {15'h0000, run_sum[9]};
      end
      else if (tick_i)
        cnt_r <= cnt_r + 16'h0001;
    end
  end

  assign clk_o = out_r;
  assign active_o = act_r;
  assign loaded_o = ld_r;

  default clocking dc @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  // a reload while running must sit on the falling edge of the output
  load_edge_a: assert property (
    ld_r |-> !$past(act_r) || ($past(out_r) && !out_r))
    else $error("divider reloaded mid period");
  stop_low_a: assert property (!act_r |-> !out_r)
    else $error("output high while stopped");

endmodule : rcog_divider

// >>> hdl/rcog_top.sv
// reference clock output generator with apb control registers
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module rcog_top (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [8:0] src_clk_i,
  input wire logic idle_mode_i,
  input wire logic sleep_mode_i,
  output logic ref_clock_out_pin_o,
  output logic ref_clock_out_pin_oe_o
);

  rcog_pkg::rcog_ctl_t ctl_r;
  rcog_pkg::rcog_bus_t st_r;
  logic divider_switch_request_r;
  logic [14:0] integer_divisor_r;
  logic [8:0] fractional_trim_r;
  logic [8:0] src_s1_r;
  logic [8:0] src_s2_r;
  logic lvl_r;
  logic lvl_d_r;
  logic tick;
  logic run;
  logic access;
  logic wr_fire;
  logic wr_lo;
  logic wr_hi;
  logic wr_trim;
  logic div_clk;
  logic div_act;
  logic div_loaded;
  logic [31:0] rd_v;
  logic hit_v;
  logic [15:0] ctl_word;

  // reserved select codes have no source behind them
  function automatic logic rcog_src_ok(input logic [3:0] sel);
    rcog_src_ok = (sel <= rcog_pkg::SRC_PLL) ||
                  (sel == rcog_pkg::SRC_PIN);
  endfunction : rcog_src_ok

  // source clocks are foreign to clk_sys, so two flops before use;
  // a source must stay below half of clk_sys to be counted
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      src_s1_r <= 9'h000;
      src_s2_r <= 9'h000;
    end
    else
    begin
      src_s1_r <= src_clk_i;
      src_s2_r <= src_s1_r;
    end
  end

  // source select mux and rising edge detect
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      lvl_r <= 1'b0;
      lvl_d_r <= 1'b0;
    end
    else
    begin
      // select is live, so a cpu clock switch shows through
      if (rcog_src_ok(ctl_r.sel))
        lvl_r <= src_s2_r[ctl_r.sel];
      else
        lvl_r <= 1'b0;
      lvl_d_r <= lvl_r;
    end
  end

  assign tick = lvl_r && !lvl_d_r;

  // enable gated by idle and sleep keep-running bits
  assign run = ctl_r.en &&
               !(idle_mode_i && !ctl_r.sidl) &&
               !(sleep_mode_i && !ctl_r.slp);

  // apb decode; writes land at the edge that sees pready high
  assign access = psel_i && penable_i;
  assign wr_fire = access && pwrite_i &&
                   (st_r == rcog_pkg::BUS_RESP);
  assign wr_lo = wr_fire && (paddr_i == rcog_pkg::ADDR_CTL_LO);
  assign wr_hi = wr_fire && (paddr_i == rcog_pkg::ADDR_CTL_HI);
  assign wr_trim = wr_fire && (paddr_i == rcog_pkg::ADDR_TRIM);

  // control low readback, unimplemented bits tied low
  assign ctl_word = {ctl_r.en, 1'b0, ctl_r.sidl, ctl_r.oe,
                     ctl_r.slp, 1'b0, divider_switch_request_r,
                     div_act, 4'h0, ctl_r.sel};

  // read data and address hit
  always_comb
  begin
    rd_v = 32'h0000_0000;
    hit_v = 1'b1;
    case (paddr_i)
      rcog_pkg::ADDR_CTL_LO:
        rd_v[15:0] = ctl_word;
      rcog_pkg::ADDR_CTL_HI:
        rd_v[rcog_pkg::DIV_MSB:rcog_pkg::DIV_LSB] = integer_divisor_r;
      rcog_pkg::ADDR_TRIM:
        rd_v[rcog_pkg::TRIM_MSB:rcog_pkg::TRIM_LSB] = fractional_trim_r;
      default:
        hit_v = 1'b0;
    endcase
  end

  // apb answer: one wait state, then pready with data or error
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      st_r <= rcog_pkg::BUS_IDLE;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      case (st_r)
        rcog_pkg::BUS_IDLE:
        begin
          if (access)
          begin
            st_r <= rcog_pkg::BUS_RESP;
            pready_o <= 1'b1;
            pslverr_o <= !hit_v;
            prdata_o <= pwrite_i ? 32'h0000_0000 : rd_v;
          end
        end
        rcog_pkg::BUS_RESP:
        begin
          st_r <= rcog_pkg::BUS_IDLE;
          pready_o <= 1'b0;
          pslverr_o <= 1'b0;
          prdata_o <= 32'h0000_0000;
        end
        default:
        begin
          st_r <= rcog_pkg::BUS_IDLE;
          pready_o <= 1'b0;
          pslverr_o <= 1'b0;
          prdata_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  // control fields written by software
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      ctl_r.en <= 1'b0;
      ctl_r.sidl <= 1'b0;
      ctl_r.oe <= 1'b0;
      ctl_r.slp <= 1'b0;
      ctl_r.sel <= rcog_pkg::SEL_RST;
    end
    else if (wr_lo)
    begin
      ctl_r.en <= pwdata_i[rcog_pkg::BIT_EN];
      ctl_r.sidl <= pwdata_i[rcog_pkg::BIT_SIDL];
      ctl_r.oe <= pwdata_i[rcog_pkg::BIT_OE];
      ctl_r.slp <= pwdata_i[rcog_pkg::BIT_SLP];
      ctl_r.sel <= pwdata_i[rcog_pkg::SEL_MSB:rcog_pkg::SEL_LSB];
    end
  end

  // switch request: software set wins over hardware clear,
  // writing zero does not withdraw a pending request
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      divider_switch_request_r <= 1'b0;
    else if (wr_lo && pwdata_i[rcog_pkg::BIT_SWREQ])
      divider_switch_request_r <= 1'b1;
    else if (div_loaded)
      divider_switch_request_r <= 1'b0;
  end

  // divisor and trim staging; the divider copies them on request
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      integer_divisor_r <= rcog_pkg::DIV_RST;
      fractional_trim_r <= rcog_pkg::TRIM_RST;
    end
    else
    begin
      if (wr_hi)
        integer_divisor_r <=
          pwdata_i[rcog_pkg::DIV_MSB:rcog_pkg::DIV_LSB];
      if (wr_trim)
        fractional_trim_r <=
          pwdata_i[rcog_pkg::TRIM_MSB:rcog_pkg::TRIM_LSB];
    end
  end

  // divider with boundary-aligned reload
  rcog_divider u_div (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .tick_i(tick),
    .src_lvl_i(lvl_r),
    .run_i(run),
    .load_i(divider_switch_request_r),
    .div_i(integer_divisor_r),
    .trim_i(fractional_trim_r),
    .clk_o(div_clk),
    .active_o(div_act),
    .loaded_o(div_loaded)
  );

  // pin outputs; the clock is masked so the pin rests low
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      ref_clock_out_pin_o <= 1'b0;
      ref_clock_out_pin_oe_o <= 1'b0;
    end
    else
    begin
      ref_clock_out_pin_o <= div_clk && ctl_r.oe;
      ref_clock_out_pin_oe_o <= ctl_r.oe;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  pin_masked_a: assert property (
    !ctl_r.oe |=> !ref_clock_out_pin_o)
    else $error("clock on pin while output disabled");

  pin_follow_a: assert property (
    ctl_r.oe && div_clk |=> ref_clock_out_pin_o)
    else $error("pin misses divider clock");

  start_run_a: assert property (
    run && !div_act |=> div_act)
    else $error("enabled divider did not start");

  idle_stop_a: assert property (
    idle_mode_i && !ctl_r.sidl && !div_act |=> !div_act)
    else $error("started during idle without keep bit");

  sleep_stop_a: assert property (
    sleep_mode_i && !ctl_r.slp && !div_act |=> !div_act)
    else $error("started during sleep without keep bit");

  swreq_hold_a: assert property (
    divider_switch_request_r && !div_loaded
      |=> divider_switch_request_r)
    else $error("switch request dropped before reload");

  swreq_clear_a: assert property (
    div_loaded && !(wr_lo && pwdata_i[rcog_pkg::BIT_SWREQ])
      |=> !divider_switch_request_r)
    else $error("switch request not cleared after reload");

  active_read_a: assert property (
    st_r == rcog_pkg::BUS_IDLE && access && !pwrite_i &&
    paddr_i == rcog_pkg::ADDR_CTL_LO
      |=> prdata_o[rcog_pkg::BIT_ACT] == $past(div_act))
    else $error("active bit readback wrong");

  zero_bits_a: assert property (
    st_r == rcog_pkg::BUS_RESP
      |-> prdata_o[31:16] == 16'h0000 &&
          (paddr_i != rcog_pkg::ADDR_CTL_LO ||
           (!prdata_o[14] && !prdata_o[10] &&
            prdata_o[7:4] == 4'h0)))
    else $error("unimplemented bits read nonzero");

  reserved_sel_a: assert property (
    !rcog_src_ok(ctl_r.sel) |=> !lvl_r)
    else $error("reserved select produced a source");

  trim_store_a: assert property (
    wr_trim |=> fractional_trim_r == $past(pwdata_i[15:7]))
    else $error("trim field not stored");

  div_store_a: assert property (
    wr_hi |=> integer_divisor_r == $past(pwdata_i[14:0]))
    else $error("divisor field not stored");

  enable_store_a: assert property (
    wr_lo |=> ctl_r.en == $past(pwdata_i[15]))
    else $error("enable bit not stored");

  stay_stopped_a: assert property (
    !ctl_r.en && !div_act |=> !div_act)
    else $error("divider active while disabled");

  map_error_a: assert property (
    st_r == rcog_pkg::BUS_IDLE && access |=> pslverr_o == !$past(hit_v))
    else $error("bus error flag wrong");

  bus_answer_a: assert property (
    st_r == rcog_pkg::BUS_IDLE && access |=> pready_o ##1 !pready_o)
    else $error("apb answer timing wrong");

  switch_c: cover property (
    divider_switch_request_r && div_act ##[1:1000] div_loaded);
  disable_c: cover property ($fell(ctl_r.en) ##[1:1000] !div_act);
  pin_c: cover property (ctl_r.oe && $rose(ref_clock_out_pin_o));

endmodule : rcog_top

// >>> testbench/rcog_ref_sink.sv
// model of an external device clocked by the reference output
`timescale 1ns/1ps
module rcog_ref_sink (
  input wire logic clk_sys_i,
  input wire logic ref_i,
  output int rises_o,
  output int stamp_o
);
  int cyc = 0;
  int rise_cnt = 0;
  int rise_at = 0;
  logic ref_q = 1'b0;

  // a consumer only sees edges; stamps let the bench measure periods
  assign rises_o = rise_cnt;
  assign stamp_o = rise_at;

  // count rising edges and time-stamp the latest in system cycles
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    ref_q <= ref_i;
    if (ref_i && !ref_q)
    begin
      rise_cnt <= rise_cnt + 1;
      rise_at <= cyc;
    end
  end
endmodule : rcog_ref_sink

// >>> testbench/rcog_top_tb.sv
// self-checking bench of the reference clock output generator
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    checks++; \
    if ((got) !== (ex)) \
    begin \
      failures++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end

module rcog_top_tb;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [8:0] src_clk_i = 9'h000;
  logic idle_mode_i = 1'b0;
  logic sleep_mode_i = 1'b0;
  logic pin_o;
  logic pin_oe_o;
  logic [31:0] rdat;
  logic err;
  int rises;
  int stamp;
  int cyc = 0;
  int checks = 0;
  int failures = 0;

  rcog_top dut (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .paddr_i(paddr_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .src_clk_i(src_clk_i),
    .idle_mode_i(idle_mode_i),
    .sleep_mode_i(sleep_mode_i),
    .ref_clock_out_pin_o(pin_o),
    .ref_clock_out_pin_oe_o(pin_oe_o)
  );

  rcog_ref_sink sink (
    .clk_sys_i(clk_sys_i),
    .ref_i(pin_o),
    .rises_o(rises),
    .stamp_o(stamp)
  );

  // system clock, 25 ns period
  always #12.5 clk_sys_i = ~clk_sys_i;

  // source k has half periods of k+2 cycles so each select is distinct;
  // outputs stay far below the pin frequency limits
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    for (int k = 0; k < 9; k++)
      src_clk_i[k] <= ((cyc / (k + 2)) % 2) == 1;
  end

  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  // one apb transfer; the request stands until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    rdat = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1)
    begin
      `CHK("pready", 1'b1, pready_o)
      conclude();
    end
  endtask : apb

  // poll one control bit; status bits change only at period ends or while stopped
  task automatic wait_bit(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, rcog_pkg::ADDR_CTL_LO, 32'h00000000);
      n++;
    end
    while (rdat[b] !== v && n < 100);
    `CHK("ctl bit", v, rdat[b])
    if (rdat[b] !== v)
      conclude();
  endtask : wait_bit

  // time n output periods between rising edges seen by the sink
  task automatic period(input int n, input int ex);
    int r;
    int t0;
    int k;
    k = 0;
    r = rises;
    while (rises < r + 2 && k < 4000)
    begin
      @(posedge clk_sys_i);
      k++;
    end
    t0 = stamp;
    r = rises;
    while (rises < r + n && k < 4000)
    begin
      @(posedge clk_sys_i);
      k++;
    end
    `CHK("period", ex, stamp - t0)
    if (k >= 4000)
    begin
      failures++;
      conclude();
    end
  endtask : period

  // stop, then change settings and request the switch in the safe order
  task automatic start(input logic [3:0] s, input logic [14:0] d,
                       input logic [8:0] t, input logic [15:0] b);
    // clear only enable so the source is not touched while active
    apb(1'b0, rcog_pkg::ADDR_CTL_LO, 32'h00000000);
    apb(1'b1, rcog_pkg::ADDR_CTL_LO, {16'h0000, rdat[15:0] & 16'h380F});
    wait_bit(8, 1'b0);
    wait_bit(9, 1'b0);
    apb(1'b1, rcog_pkg::ADDR_TRIM, {16'h0000, t, 7'h00});
    apb(1'b1, rcog_pkg::ADDR_CTL_HI, {17'h00000, d});
    apb(1'b1, rcog_pkg::ADDR_CTL_LO, {16'h0000, b | 16'h0200 | s});
    wait_bit(9, 1'b0);
  endtask : start

  task automatic t_regs;
    apb(1'b0, rcog_pkg::ADDR_CTL_LO, 32'h00000000);
    `CHK("ctl reset", 32'h00000000, rdat)
    apb(1'b0, 12'h00C, 32'h00000000);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, rcog_pkg::ADDR_CTL_LO, 32'h000074F7);
    apb(1'b0, rcog_pkg::ADDR_CTL_LO, 32'h00000000);
    `CHK("ctl unused", 32'h00003007, rdat)
    `CHK("pin enable", 1'b1, pin_oe_o)
    apb(1'b1, rcog_pkg::ADDR_CTL_HI, 32'h0000FFFF);
    apb(1'b0, rcog_pkg::ADDR_CTL_HI, 32'h00000000);
    `CHK("divisor", 32'h00007FFF, rdat)
    apb(1'b1, rcog_pkg::ADDR_TRIM, 32'h0000FFFF);
    apb(1'b0, rcog_pkg::ADDR_TRIM, 32'h00000000);
    `CHK("trim", 32'h0000FF80, rdat)
    $display("test regs done");
  endtask : t_regs

  task automatic t_sources;
    logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3,
                              4'h4, 4'h5, 4'h6, 4'h8};
    foreach (codes[i])
    begin
      start(codes[i], 15'h0001, 9'h000, 16'h9000);
      wait_bit(8, 1'b1);
      period(1, 4 * (codes[i] + 2));
    end
    $display("test sources done");
  endtask : t_sources

  task automatic t_ratio;
    start(rcog_pkg::SRC_PRIMARY, 15'h0000, 9'h000, 16'h9000);
    period(1, 8);
    start(rcog_pkg::SRC_PRIMARY, 15'h0003, 9'h000, 16'h9000);
    period(1, 48);
    start(rcog_pkg::SRC_CPU, 15'h0001, 9'h100, 16'h9000);
    period(2, 24);
    $display("test ratio done");
  endtask : t_ratio

  task automatic t_modes;
    logic seen;
    seen = 1'b0;
    start(rcog_pkg::SRC_CPU, 15'h0001, 9'h000, 16'h8000);
    wait_bit(8, 1'b1);
    repeat (40)
    begin
      @(posedge clk_sys_i);
      seen = seen | pin_o;
    end
    `CHK("pin quiet", 1'b0, seen)
    `CHK("pin enable", 1'b0, pin_oe_o)
    apb(1'b1, rcog_pkg::ADDR_CTL_LO, 32'h00009000);
    period(1, 8);
    idle_mode_i <= 1'b1;
    wait_bit(8, 1'b0);
    apb(1'b1, rcog_pkg::ADDR_CTL_LO, 32'h0000B000);
    wait_bit(8, 1'b1);
    period(1, 8);
    idle_mode_i <= 1'b0;
    sleep_mode_i <= 1'b1;
    apb(1'b1, rcog_pkg::ADDR_CTL_LO, 32'h00009000);
    wait_bit(8, 1'b0);
    apb(1'b1, rcog_pkg::ADDR_CTL_LO, 32'h00009800);
    wait_bit(8, 1'b1);
    sleep_mode_i <= 1'b0;
    apb(1'b1, rcog_pkg::ADDR_CTL_LO, 32'h00001000);
    wait_bit(8, 1'b0);
    repeat (8) @(posedge clk_sys_i);
    `CHK("pin stopped", 1'b0, pin_o)
    $display("test modes done");
  endtask : t_modes

  // reset for three cycles, then run every scenario
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_sources();
    t_ratio();
    t_modes();
    conclude();
  end
endmodule : rcog_top_tb
